// file: rtl/ess_supervisor.sv
// Engine supervision: speed, fuel pump, crank cut, warnings, timers, clock trim
//
// Contract
// - Speed from frequency times sixty over pole pairs
// - Speed source: 0 pickup, 1 frequency
// - Pickup speed divides pulses by teeth count
// - Pump on below low fuel threshold
// - Pump off above high fuel threshold
// - Crank cut: switch or sender, or switch only
// - Alarm during start delay when prewarn set
// - Latch all keeps warnings until manual reset
// - Low limit raised by hysteresis after mains failure
// - Flashing relay on/off minute timers, dual genset
// - Delayed simulate mains limits run time
// - Engine only mode ignores alternator
// - Trim 0..63 speeds up clock
// - Trim 127 down to 64 slows clock
`timescale 1ns/100ps
`default_nettype none
module ess_supervisor #(
  parameter int WN         = 8,
  parameter int SEC_CYCLES = ess_pkg::RTC_SEC_CYCLES
) (
  // Clock and reset
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  // Settings
  input  wire logic [3:0]    pole_pairs_in,
  input  wire logic          speed_src_in,
  input  wire logic [7:0]    teeth_in,
  input  wire logic [6:0]    fuel_lo_in,
  input  wire logic [6:0]    fuel_hi_in,
  input  wire logic          crank_prio_in,
  input  wire logic          prewarn_in,
  input  wire logic          latch_all_in,
  input  wire logic [4:0]    hyst_in,
  input  wire logic [10:0]   flash_on_min_in,
  input  wire logic [10:0]   flash_off_min_in,
  input  wire logic          eng_only_in,
  input  wire logic [7:0]    rtc_trim_in,
  input  wire logic          dual_genset_in,
  input  wire logic          delayed_sim_in,
  // Pins
  input  wire logic          magnetic_pickup_input,
  input  wire logic          oil_switch_in,
  // Measurements and events
  input  wire logic [15:0]   gen_freq_hz_in,
  input  wire logic [6:0]    fuel_level_in,
  input  wire logic          oil_sender_ok_in,
  input  wire logic          start_delay_in,
  input  wire logic          alarm_req_in,
  input  wire logic          mains_present_in,
  input  wire logic [9:0]    low_limit_in,
  input  wire logic          sim_mains_in,
  input  wire logic [WN-1:0] warn_src_in,
  input  wire logic [WN-1:0] warn_latch_en_in,
  input  wire logic          warn_reset_in,
  // Results
  output logic [15:0]        engine_rpm_out,
  output logic               fuel_pump_out,
  output logic               crank_cut_out,
  output logic               alarm_out,
  output logic [10:0]        eff_low_limit_out,
  output logic               alt_monitor_en_out,
  output logic [WN-1:0]      warn_out,
  output logic               flash_relay_out,
  output logic               sim_run_out,
  output logic               rtc_sec_out
);

  localparam logic [26:0] SEC_LAST = 27'(SEC_CYCLES);
  localparam logic [18:0] TRIM_D   = 19'(ess_pkg::TRIM_DEN);
  localparam logic [5:0]  MIN_LAST = 6'(ess_pkg::SEC_PER_MIN - 1);

  typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF} ess_flash_e;

  typedef struct packed {
    logic [3:0]    pp;
    logic          src;
    logic [7:0]    teeth;
    logic [6:0]    lo;
    logic [6:0]    hi;
    logic          crank;
    logic          prewarn;
    logic          latch_all;
    logic [4:0]    hyst;
    logic [10:0]   on_min;
    logic [10:0]   off_min;
    logic          eng_only;
    logic [7:0]    trim;
    logic [2:0]    mpu_sync;
    logic          mpu_lvl;
    logic [2:0]    osw_sync;
    logic          osw_lvl;
    logic [19:0]   pulses;
    logic [26:0]   rtc_cnt;
    logic [18:0]   trim_acc;
    logic          sec;
    logic [5:0]    sec_cnt;
    logic          min;
    logic          div_go;
    logic [27:0]   div_num;
    logic [7:0]    div_den;
    logic [15:0]   rpm;
    logic          pump;
    logic [WN-1:0] latched;
    logic [WN-1:0] warn;
    logic          crank_cut;
    logic          alarm;
    logic [10:0]   low_lim;
    logic          alt_en;
    ess_flash_e    fl_state;
    logic [10:0]   fl_cnt;
    logic          flash;
    logic          sim_d;
    logic          hold;
    logic [10:0]   hold_cnt;
    logic          sim_run;
  } ess_state_s;

  ess_state_s   st;
  ess_state_s   next_st;
  logic         div_done;
  logic [27:0]  div_quo;

  // Times sixty by shifts
  function automatic logic [27:0] times60(input logic [19:0] x);
    logic [27:0] w;
    w = {8'h00, x};
    return (w << 6) - (w << 2);
  endfunction

  function automatic logic [3:0] clamp_pp(input logic [3:0] v);
    if (v < ess_pkg::POLE_PAIRS_MIN) return ess_pkg::POLE_PAIRS_MIN;
    if (v > ess_pkg::POLE_PAIRS_MAX) return ess_pkg::POLE_PAIRS_MAX;
    return v;
  endfunction

  function automatic logic [7:0] clamp_teeth(input logic [7:0] v);
    if (v < ess_pkg::TEETH_MIN) return ess_pkg::TEETH_MIN;
    if (v > ess_pkg::TEETH_MAX) return ess_pkg::TEETH_MAX;
    return v;
  endfunction

  function automatic logic [10:0] clamp_min(input logic [10:0] v);
    return (v > ess_pkg::FLASH_MIN_MAX) ? ess_pkg::FLASH_MIN_MAX : v;
  endfunction

  ess_divider #(
    .NW (28),
    .DW (8)
  ) u_div (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .start_in   (st.div_go),
    .num_in     (st.div_num),
    .den_in     (st.div_den),
    .done_out   (div_done),
    .quo_out    (div_quo)
  );

  always_comb begin
    logic        use_freq;
    logic [26:0] rtc_next;
    logic [18:0] acc_sum;
    logic [7:0]  steps;
    logic        fast;
    logic        slow;
    logic        sim_fall;
    use_freq = 1'b0;
    rtc_next = '0;
    acc_sum  = '0;
    steps    = '0;
    fast     = 1'b0;
    slow     = 1'b0;
    sim_fall = 1'b0;
    next_st  = st;

    // Settings, clamped to their legal ranges
    next_st.pp        = clamp_pp(pole_pairs_in);
    next_st.src       = speed_src_in;
    next_st.teeth     = clamp_teeth(teeth_in);
    next_st.lo        = fuel_lo_in;
    next_st.hi        = fuel_hi_in;
    next_st.crank     = crank_prio_in;
    next_st.prewarn   = prewarn_in;
    next_st.latch_all = latch_all_in;
    next_st.hyst      = (hyst_in > ess_pkg::HYST_MAX) ? ess_pkg::HYST_MAX : hyst_in;
    next_st.on_min    = clamp_min(flash_on_min_in);
    next_st.off_min   = clamp_min(flash_off_min_in);
    next_st.eng_only  = eng_only_in;
    next_st.trim      = rtc_trim_in;

    // Pin synchronisers, a change counts once stages two and three agree
    next_st.mpu_sync = {st.mpu_sync[1:0], magnetic_pickup_input};
    next_st.osw_sync = {st.osw_sync[1:0], oil_switch_in};
    if (st.mpu_sync[1] == st.mpu_sync[2]) begin
      next_st.mpu_lvl = st.mpu_sync[2];
    end
    if (st.osw_sync[1] == st.osw_sync[2]) begin
      next_st.osw_lvl = st.osw_sync[2];
    end

    // Trimmed one-second time base
    if (st.trim <= ess_pkg::TRIM_FAST_TOP) begin
      steps = st.trim;
      fast  = 1'b1;
    end else if (st.trim <= ess_pkg::TRIM_SLOW_TOP) begin
      steps = ess_pkg::TRIM_SLOW_BASE - st.trim;
      slow  = 1'b1;
    end
    acc_sum  = st.trim_acc + {11'h000, steps};
    rtc_next = st.rtc_cnt + 27'h0000001;
    if (acc_sum >= TRIM_D) begin
      // A quarter second gained or lost per day and step
      next_st.trim_acc = acc_sum - TRIM_D;
      if (fast) begin
        rtc_next = st.rtc_cnt + 27'h0000002;
      end else if (slow) begin
        rtc_next = st.rtc_cnt;
      end
    end else begin
      next_st.trim_acc = acc_sum;
    end
    next_st.sec = 1'b0;
    next_st.min = 1'b0;
    if (rtc_next >= SEC_LAST) begin
      next_st.rtc_cnt = rtc_next - SEC_LAST;
      next_st.sec     = 1'b1;
    end else begin
      next_st.rtc_cnt = rtc_next;
    end
    if (st.sec) begin
      if (st.sec_cnt == MIN_LAST) begin
        next_st.sec_cnt = '0;
        next_st.min     = 1'b1;
      end else begin
        next_st.sec_cnt = st.sec_cnt + 6'h01;
      end
    end

    // Engine speed, refreshed once per second
    // Without an alternator only the pickup can give speed
    use_freq = st.src && !st.eng_only;
    next_st.div_go = 1'b0;
    if (st.sec) begin
      next_st.div_go = 1'b1;
      if (use_freq) begin
        next_st.div_num = times60({4'h0, gen_freq_hz_in});
        next_st.div_den = {4'h0, st.pp};
      end else begin
        next_st.div_num = times60(st.pulses);
        next_st.div_den = st.teeth;
      end
      next_st.pulses = '0;
    end
    if (!st.mpu_lvl && next_st.mpu_lvl && (next_st.pulses != '1)) begin
      next_st.pulses = next_st.pulses + 20'h00001;
    end
    if (div_done) begin
      next_st.rpm = (div_quo[27:16] != '0) ? 16'hffff : div_quo[15:0];
    end

    // Fuel pump with hysteresis band
    if (fuel_level_in > st.hi) begin
      next_st.pump = 1'b0;
    end else if (fuel_level_in < st.lo) begin
      next_st.pump = 1'b1;
    end else begin
      next_st.pump = st.pump;
    end

    // Crank cut, alarm, voltage limit
    if (st.crank == ess_pkg::CRANK_SWITCH_ONLY) begin
      next_st.crank_cut = st.osw_lvl;
    end else begin
      next_st.crank_cut = st.osw_lvl || oil_sender_ok_in;
    end
    next_st.alarm   = alarm_req_in || (st.prewarn && start_delay_in);
    next_st.low_lim = mains_present_in ? {1'b0, low_limit_in}
                                       : {1'b0, low_limit_in} + {6'h00, st.hyst};
    next_st.alt_en  = !st.eng_only;

    // Warnings; a new fault beats a reset in the same cycle
    next_st.latched = (warn_reset_in ? '0 : st.latched)
                    | (warn_src_in & (st.latch_all ? '1 : warn_latch_en_in));
    next_st.warn    = warn_src_in | next_st.latched;

    // Flashing relay for dual genset systems
    case (st.fl_state)
      FL_IDLE: begin
        next_st.flash = 1'b0;
        if (dual_genset_in && (st.on_min != '0)) begin
          next_st.fl_state = FL_ON;
          next_st.fl_cnt   = '0;
          next_st.flash    = 1'b1;
        end
      end
      FL_ON: begin
        if (st.min) begin
          next_st.fl_cnt = st.fl_cnt + 11'h001;
          if ((next_st.fl_cnt >= st.on_min) && (st.off_min != '0)) begin
            next_st.fl_state = FL_OFF;
            next_st.fl_cnt   = '0;
            next_st.flash    = 1'b0;
          end else if (next_st.fl_cnt >= st.on_min) begin
            next_st.fl_cnt = '0;
          end
        end
      end
      FL_OFF: begin
        if (st.min) begin
          next_st.fl_cnt = st.fl_cnt + 11'h001;
          if ((next_st.fl_cnt >= st.off_min) && (st.on_min != '0)) begin
            next_st.fl_state = FL_ON;
            next_st.fl_cnt   = '0;
            next_st.flash    = 1'b1;
          end else if (next_st.fl_cnt >= st.off_min) begin
            next_st.fl_cnt = '0;
          end
        end
      end
      default: begin
        next_st.fl_state = FL_IDLE;
        next_st.flash    = 1'b0;
      end
    endcase
    if (!dual_genset_in) begin
      next_st.fl_state = FL_IDLE;
      next_st.flash    = 1'b0;
    end

    // Delayed simulate mains: run on for at most the ON time
    next_st.sim_d = sim_mains_in;
    sim_fall      = st.sim_d && !sim_mains_in;
    if (sim_mains_in || !delayed_sim_in) begin
      next_st.hold = 1'b0;
    end else if (sim_fall && (st.on_min != '0)) begin
      next_st.hold     = 1'b1;
      next_st.hold_cnt = '0;
    end else if (st.hold && st.min) begin
      next_st.hold_cnt = st.hold_cnt + 11'h001;
      if (next_st.hold_cnt >= st.on_min) begin
        next_st.hold = 1'b0;
      end
    end
    next_st.sim_run = sim_mains_in || next_st.hold;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st           <= '0;
      st.pp        <= ess_pkg::POLE_PAIRS_RST;
      st.src       <= ess_pkg::SPEED_SRC_RST;
      st.teeth     <= ess_pkg::TEETH_RST;
      st.lo        <= ess_pkg::FUEL_LO_RST;
      st.hi        <= ess_pkg::FUEL_HI_RST;
      st.crank     <= ess_pkg::CRANK_PRIO_RST;
      st.prewarn   <= ess_pkg::PREWARN_RST;
      st.latch_all <= ess_pkg::LATCH_ALL_RST;
      st.hyst      <= ess_pkg::HYST_RST;
      st.on_min    <= ess_pkg::FLASH_MIN_RST;
      st.off_min   <= ess_pkg::FLASH_MIN_RST;
      st.eng_only  <= ess_pkg::ENG_ONLY_RST;
      st.trim      <= ess_pkg::TRIM_RST;
      st.alt_en    <= 1'b1;
      st.fl_state  <= FL_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign engine_rpm_out     = st.rpm;
  assign fuel_pump_out      = st.pump;
  assign crank_cut_out      = st.crank_cut;
  assign alarm_out          = st.alarm;
  assign eff_low_limit_out  = st.low_lim;
  assign alt_monitor_en_out = st.alt_en;
  assign warn_out           = st.warn;
  assign flash_relay_out    = st.flash;
  assign sim_run_out        = st.sim_run;
  assign rtc_sec_out        = st.sec;

endmodule
`default_nettype wire

// file: rtl/ess_pkg.sv
// Shared constants of the engine supervision logic
package ess_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 40_000_000;
  localparam int RTC_SEC_S      = 1;
  localparam int RTC_SEC_CYCLES = CLK_HZ * RTC_SEC_S;
  localparam int SEC_PER_MIN    = 60;
  localparam int RPM_PER_HZ     = 60;
  // Quarter seconds in one day: one trim step is one cycle in this many
  localparam int TRIM_DEN       = 86400 * 4;

  // ----------------------------------------------------------------
  // Settings: values after reset, limits and codes
  // ----------------------------------------------------------------
  localparam logic [3:0]  POLE_PAIRS_RST = 4'h2;
  localparam logic [3:0]  POLE_PAIRS_MIN = 4'h1;
  localparam logic [3:0]  POLE_PAIRS_MAX = 4'h8;
  localparam logic        SPEED_SRC_RST  = 1'b1;
  localparam logic        SPEED_SRC_PICKUP = 1'b0;
  localparam logic [7:0]  TEETH_RST      = 8'h1e;
  localparam logic [7:0]  TEETH_MIN      = 8'h01;
  localparam logic [7:0]  TEETH_MAX      = 8'hf4;
  localparam logic [6:0]  FUEL_LO_RST    = 7'h14;
  localparam logic [6:0]  FUEL_HI_RST    = 7'h50;
  localparam logic        CRANK_SWITCH_ONLY = 1'b1;
  localparam logic        CRANK_PRIO_RST = 1'b0;
  localparam logic        PREWARN_RST    = 1'b1;
  localparam logic        LATCH_ALL_RST  = 1'b0;
  localparam logic [4:0]  HYST_RST       = 5'h08;
  localparam logic [4:0]  HYST_MAX       = 5'h1e;
  localparam logic [10:0] FLASH_MIN_RST  = 11'h000;
  localparam logic [10:0] FLASH_MIN_MAX  = 11'h4b0;
  localparam logic        ENG_ONLY_RST   = 1'b0;
  localparam logic [7:0]  TRIM_RST       = 8'h75;
  localparam logic [7:0]  TRIM_FAST_TOP  = 8'h3f;
  localparam logic [7:0]  TRIM_SLOW_TOP  = 8'h7f;
  localparam logic [7:0]  TRIM_SLOW_BASE = 8'h80;

endpackage

// file: rtl/ess_divider.sv
// Sequential restoring divider used for the speed conversion
`timescale 1ns/100ps
`default_nettype none
module ess_divider #(
  parameter int NW = 28,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  // Request
  input  wire logic          start_in,
  input  wire logic [NW-1:0] num_in,
  input  wire logic [DW-1:0] den_in,
  // Answer
  output logic               done_out,
  output logic [NW-1:0]      quo_out
);

  typedef struct packed {
    logic            busy;
    logic [5:0]      cnt;
    logic [NW-1:0]   num;
    logic [DW-1:0]   den;
    logic [DW:0]     rem;
    logic            done;
    logic [NW-1:0]   quo;
  } ess_div_s;

  ess_div_s st;
  ess_div_s next_st;

  always_comb begin
    logic [DW:0] trial;
    trial = '0;
    next_st = st;
    next_st.done = 1'b0;
    if (!st.busy) begin
      if (start_in) begin
        next_st.busy = 1'b1;
        next_st.cnt  = 6'(NW);
        next_st.num  = num_in;
        next_st.den  = den_in;
        next_st.rem  = '0;
      end
    end else begin
      trial = {st.rem[DW-1:0], st.num[NW-1]};
      next_st.num = {st.num[NW-2:0], 1'b0};
      if (trial >= {1'b0, st.den}) begin
        next_st.rem = trial - {1'b0, st.den};
        next_st.num[0] = 1'b1;
      end else begin
        next_st.rem = trial;
      end
      next_st.cnt = st.cnt - 6'h01;
      if (st.cnt == 6'h01) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        // A zero divisor saturates rather than hanging
        next_st.quo  = (st.den == '0) ? '1 : {st.num[NW-2:0], next_st.num[0]};
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done_out = st.done;
  assign quo_out  = st.quo;

endmodule
`default_nettype wire

// file: bench/ess_sense_model.sv
// Behavioural model of the pickup sensor and the oil pressure switch
`timescale 1ns/100ps
`default_nettype none
module ess_sense_model (
  // Clock
  input  wire logic sys_clk_in,
  // Bench control
  input  wire logic spin_in,
  input  wire logic press_in,
  // Sensor pins
  output logic      pickup_out,
  output logic      oil_switch_out
);
  logic [3:0] phase = 4'h0;
  initial pickup_out = 1'b0;
  initial oil_switch_out = 1'b0;
  // ----------------------------------------------------------------
  // Tooth pulses
  // ----------------------------------------------------------------
  // Five high, five low: well above the two-cycle filter of the pin
  always @(posedge sys_clk_in) begin
    #2;
    phase = (phase == 4'h9) ? 4'h0 : phase + 4'h1;
    pickup_out = spin_in && (phase < 4'h5);
    oil_switch_out = press_in;
  end
endmodule
`default_nettype wire

// file: bench/ess_supervisor_sva.sv
// Concurrent checks on the engine supervision ports
`timescale 1ns/100ps
`default_nettype none
module ess_supervisor_sva #(
  parameter int WN = 8
) (
  // Clock and reset
  input wire logic          sys_clk_in,
  input wire logic          rst_in,
  // Watched inputs
  input wire logic [6:0]    fuel_lo_in,
  input wire logic [6:0]    fuel_hi_in,
  input wire logic [6:0]    fuel_level_in,
  input wire logic          crank_prio_in,
  input wire logic          oil_switch_in,
  input wire logic          oil_sender_ok_in,
  input wire logic          prewarn_in,
  input wire logic          start_delay_in,
  input wire logic          alarm_req_in,
  input wire logic          mains_present_in,
  input wire logic [9:0]    low_limit_in,
  input wire logic [4:0]    hyst_in,
  input wire logic          latch_all_in,
  input wire logic [WN-1:0] warn_src_in,
  input wire logic          warn_reset_in,
  input wire logic          dual_genset_in,
  // Watched outputs
  input wire logic          fuel_pump_out,
  input wire logic          crank_cut_out,
  input wire logic          alarm_out,
  input wire logic [10:0]   eff_low_limit_out,
  input wire logic [WN-1:0] warn_out,
  input wire logic          flash_relay_out,
  input wire logic          rtc_sec_out
);
  // ----------------------------------------------------------------
  // Settle counter
  // ----------------------------------------------------------------
  // Settings lag the ports by one cycle
  logic [1:0] age;
  logic       ok;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) age <= 2'h0;
    else if (age != 2'h3) age <= age + 2'h1;
  end
  assign ok = (age == 2'h3);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_switch_low;
    (crank_prio_in && !oil_switch_in)[*6];
  endsequence
  sequence s_sender_ok;
    (!crank_prio_in && oil_sender_ok_in)[*3];
  endsequence
  sequence s_clear;
    (warn_reset_in && warn_src_in == '0)[*2];
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  pump_on_a: assert property (ok && fuel_level_in < fuel_lo_in && fuel_level_in <= fuel_hi_in
    && $stable(fuel_lo_in) && $stable(fuel_hi_in) |=> fuel_pump_out) else $error("pump not on");
  pump_off_a: assert property (ok && fuel_level_in > fuel_hi_in && $stable(fuel_hi_in)
    |=> !fuel_pump_out) else $error("pump not off");
  pump_hold_a: assert property (ok && fuel_level_in >= fuel_lo_in && fuel_level_in <= fuel_hi_in
    && $stable(fuel_lo_in) && $stable(fuel_hi_in) |=> $stable(fuel_pump_out))
    else $error("pump changed inside band");
  crank_sw_a: assert property (s_switch_low |=> !crank_cut_out) else $error("crank cut by sender");
  crank_or_a: assert property (s_sender_ok |=> crank_cut_out) else $error("sender ignored");
  alarm_pre_a: assert property (ok && prewarn_in && $stable(prewarn_in) && start_delay_in
    |=> alarm_out) else $error("no alarm in start delay");
  alarm_quiet_a: assert property (ok && !prewarn_in && $stable(prewarn_in) && !alarm_req_in
    |=> !alarm_out) else $error("alarm without cause");
  limit_hyst_a: assert property (ok && $stable(hyst_in) && hyst_in <= 5'h1e
    |=> eff_low_limit_out == {1'b0, $past(low_limit_in)}
      + ($past(mains_present_in) ? 11'h000 : {6'h00, $past(hyst_in)})) else $error("bad limit");
  warn_src_a: assert property (ok |=> (warn_out & $past(warn_src_in)) == $past(warn_src_in))
    else $error("warning source lost");
  warn_keep_a: assert property (ok && $past(latch_all_in, 2) && !warn_reset_in
    |=> (warn_out & $past(warn_out)) == $past(warn_out)) else $error("warning dropped");
  warn_clear_a: assert property (s_clear |=> warn_out == '0) else $error("warning not cleared");
  flash_idle_a: assert property ((!dual_genset_in)[*2] |=> !flash_relay_out)
    else $error("flash relay on while disabled");
  sec_pulse_a: assert property (rtc_sec_out |=> !rtc_sec_out) else $error("second pulse too long");
endmodule
`default_nettype wire

// file: bench/test_ess_supervisor.sv
// Self-checking bench of the engine supervision logic
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %0d got %0d", nm, e, g); end end
module test_ess_supervisor;
  localparam int SEC = 150;
  localparam int MIN = 60 * SEC;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        sys_clk_in = 1'b0, rst_in = 1'b1, speed_src_in = 1'b1, crank_prio_in = 1'b0;
  logic        prewarn_in = 1'b1, latch_all_in = 1'b0, eng_only_in = 1'b0, spin = 1'b0;
  logic        dual_genset_in = 1'b0, delayed_sim_in = 1'b0, oil_sender_ok_in = 1'b0;
  logic        start_delay_in = 1'b0, alarm_req_in = 1'b0, mains_present_in = 1'b1;
  logic        sim_mains_in = 1'b0, warn_reset_in = 1'b0, press = 1'b0;
  logic [3:0]  pole_pairs_in = 4'h2;
  logic [7:0]  teeth_in = 8'h1e, rtc_trim_in = 8'hc8, warn_src_in = 8'h00;
  logic [7:0]  warn_latch_en_in = 8'h00, warn_out;
  logic [6:0]  fuel_lo_in = 7'h14, fuel_hi_in = 7'h50, fuel_level_in = 7'h32;
  logic [4:0]  hyst_in = 5'h08;
  logic [10:0] flash_on_min_in = 11'h001, flash_off_min_in = 11'h002, eff_low_limit_out;
  logic [15:0] gen_freq_hz_in = 16'h0032, engine_rpm_out;
  logic [9:0]  low_limit_in = 10'h0c8;
  logic        magnetic_pickup_input, oil_switch_in, fuel_pump_out, crank_cut_out, alarm_out;
  logic        alt_monitor_en_out, flash_relay_out, sim_run_out, rtc_sec_out;
  logic [2:0]  mon;
  int          n_fail = 0, cmp_count = 0, n, lo, hi;
  // Trim: none, fastest, slowest
  logic [7:0]  tt [3] = '{8'hc8, 8'h3f, 8'h40};
  int          tp [3][2] = '{'{150, 150}, '{149, 150}, '{150, 151}};
  // Speed rows: source, engine only, pole pairs, teeth, rpm
  int rt [10][5] = '{'{1,0,1,30,3000}, '{1,0,2,30,1500}, '{1,0,8,30,375}, '{1,0,3,30,1000},
    '{1,0,15,30,375}, '{0,0,2,30,30}, '{0,0,2,1,900}, '{0,0,2,244,3}, '{0,0,2,255,3},
    '{1,1,2,7,128}};
  // Fuel rows: low, high, level, pump
  int ft [12][4] = '{'{20,80,50,0}, '{20,80,19,1}, '{20,80,50,1}, '{20,80,80,1},
    '{20,80,81,0}, '{20,80,20,0}, '{20,80,0,1}, '{20,80,100,0}, '{40,60,45,0},
    '{40,60,39,1}, '{40,60,59,1}, '{40,60,61,0}};
  // Rows: priority, switch, sender, crank, prewarn, delay, request, alarm, mains, hyst, limit
  int mt [4][11] = '{'{0,0,1,1, 1,1,0,1, 1,8,200}, '{1,0,1,0, 0,1,0,0, 0,8,208},
    '{1,1,0,1, 1,0,0,0, 0,30,230}, '{0,0,0,0, 0,0,1,1, 0,0,200}};
  assign mon = {rtc_sec_out, sim_run_out, flash_relay_out};
  ess_supervisor #(.WN(8), .SEC_CYCLES(SEC)) ess_supervisor_i (.*);
  ess_sense_model ess_sense_model_i (
    .sys_clk_in     (sys_clk_in),
    .spin_in        (spin),
    .press_in       (press),
    .pickup_out     (magnetic_pickup_input),
    .oil_switch_out (oil_switch_in)
  );
  initial forever #12.5 sys_clk_in = ~sys_clk_in;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk_in);
    #2;
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_lvl(input int k, input logic v, input int bound, output int c);
    c = 0;
    while (mon[k] !== v) begin
      if (c == bound) begin
        n_fail++;
        $display("MISMATCH wait %0d exp %0d got timeout", k, v);
        complete_run();
      end
      tick(1);
      c++;
    end
  endtask
  task automatic rtc_span(output int mn, output int mx);
    int c;
    mn = 1000;
    mx = 0;
    wait_lvl(2, 1'b1, 300, c);
    tick(1);
    repeat (40) begin
      wait_lvl(2, 1'b1, 300, c);
      tick(1);
      c++;
      if (c < mn) mn = c;
      if (c > mx) mx = c;
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(6);
    rst_in = 1'b0;
    spin = 1'b1;
    tick(4);
    `CHK("alt_en", 1'b1, alt_monitor_en_out)
    foreach (tt[i]) begin
      rtc_trim_in = tt[i];
      rtc_span(lo, hi);
      `CHK("sec_min", tp[i][0], lo)
      `CHK("sec_max", tp[i][1], hi)
    end
    rtc_trim_in = 8'hc8;
    foreach (rt[i]) begin
      speed_src_in = rt[i][0][0];
      eng_only_in = rt[i][1][0];
      pole_pairs_in = 4'(rt[i][2]);
      teeth_in = 8'(rt[i][3]);
      repeat (2) begin
        wait_lvl(2, 1'b1, SEC + 10, n);
        tick(1);
      end
      tick(40);
      `CHK("rpm", 16'(rt[i][4]), engine_rpm_out)
      `CHK("alt_en", ~eng_only_in, alt_monitor_en_out)
    end
    foreach (ft[i]) begin
      fuel_lo_in = 7'(ft[i][0]);
      fuel_hi_in = 7'(ft[i][1]);
      fuel_level_in = 7'(ft[i][2]);
      tick(3);
      `CHK("pump", ft[i][3][0], fuel_pump_out)
    end
    foreach (mt[i]) begin
      {crank_prio_in, press, oil_sender_ok_in} = {mt[i][0][0], mt[i][1][0], mt[i][2][0]};
      {prewarn_in, start_delay_in, alarm_req_in} = {mt[i][4][0], mt[i][5][0], mt[i][6][0]};
      mains_present_in = mt[i][8][0];
      hyst_in = 5'(mt[i][9]);
      tick(8);
      `CHK("crank", mt[i][3][0], crank_cut_out)
      `CHK("alarm", mt[i][7][0], alarm_out)
      `CHK("limit", 11'(mt[i][10]), eff_low_limit_out)
    end
    warn_latch_en_in = 8'h01;
    warn_src_in = 8'h03;
    tick(3);
    `CHK("warn_on", 8'h03, warn_out)
    warn_src_in = 8'h00;
    tick(3);
    `CHK("warn_own", 8'h01, warn_out)
    latch_all_in = 1'b1;
    warn_src_in = 8'hf0;
    tick(3);
    warn_src_in = 8'h00;
    tick(3);
    `CHK("warn_all", 8'hf1, warn_out)
    warn_src_in = 8'h80;
    warn_reset_in = 1'b1;
    tick(3);
    {warn_src_in, warn_reset_in} = 9'h000;
    tick(3);
    `CHK("warn_set_wins", 8'h80, warn_out)
    warn_reset_in = 1'b1;
    tick(3);
    warn_reset_in = 1'b0;
    `CHK("warn_clear", 8'h00, warn_out)
    dual_genset_in = 1'b1;
    tick(4);
    `CHK("flash_on", 1'b1, flash_relay_out)
    wait_lvl(0, 1'b0, MIN + 10, n);
    wait_lvl(0, 1'b1, 2 * MIN + 10, n);
    `CHK("flash_off_len", 1'b1, n >= 2 * MIN - 1 && n <= 2 * MIN + 1)
    wait_lvl(0, 1'b0, MIN + 10, n);
    `CHK("flash_on_len", 1'b1, n >= MIN - 1 && n <= MIN + 1)
    dual_genset_in = 1'b0;
    flash_on_min_in = 11'h002;
    delayed_sim_in = 1'b1;
    sim_mains_in = 1'b1;
    tick(4);
    `CHK("flash_idle", 1'b0, flash_relay_out)
    `CHK("sim_run", 1'b1, sim_run_out)
    sim_mains_in = 1'b0;
    wait_lvl(1, 1'b0, 2 * MIN + 10, n);
    `CHK("sim_hold_len", 1'b1, n >= MIN - 1 && n <= 2 * MIN + 1)
    delayed_sim_in = 1'b0;
    sim_mains_in = 1'b1;
    tick(3);
    sim_mains_in = 1'b0;
    tick(3);
    `CHK("sim_drop", 1'b0, sim_run_out)
    complete_run();
  end
endmodule
bind ess_supervisor ess_supervisor_sva #(.WN(WN)) ess_supervisor_sva_i (.*);
`default_nettype wire
